// >>> inc/xop_pkg.sv
// shared constants and carrier types for the extended-op decoder
// assumes one instruction cycle per clk_sys edge and a combinational-read data memory
package xop_pkg;
    // widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int PC_W   = 21;
    localparam int PTR_N  = 3;

    // first-byte opcodes and word patterns
    localparam logic [7:0]  OP_MOVE    = 8'heb;   // indexed moves, bit 7 picks the form
    localparam logic [7:0]  OP_PUSH    = 8'hfa;   // literal push
    localparam logic [7:0]  OP_SUB     = 8'he9;   // pointer subtract / subtract-and-return
    localparam logic [3:0]  PREFIX_2ND = 4'hf;    // second word prefix
    localparam logic [15:0] CALL_WORD  = 16'h0014;
    localparam logic [1:0]  SEL_RETURN = 2'h3;

    // field positions
    localparam int MOVE_FORM_BIT = 7;
    localparam int OFS_HI        = 6;
    localparam int SEL_HI        = 7;
    localparam int SEL_LO        = 6;
    localparam int LIT6_HI       = 5;

    // arithmetic steps and reset values
    localparam logic [ADDR_W-1:0] SP_STEP   = 12'h001;
    localparam logic [PC_W-1:0]   PC_STEP   = 21'h000002;
    localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;
    localparam logic [DATA_W-1:0] IND_DATA  = 8'h00;

    // indirect addressing register windows, one per pointer
    localparam logic [ADDR_W-1:0] IND_BASE0 = 12'hfeb;
    localparam logic [ADDR_W-1:0] IND_BASE1 = 12'hfe3;
    localparam logic [ADDR_W-1:0] IND_BASE2 = 12'hfdb;
    localparam logic [ADDR_W-1:0] IND_SPAN  = 12'h005;

    typedef enum logic [1:0] {st_idle, st_second, st_nop} seq_state_t;

    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } mem_wr_t;

    typedef struct packed {
        logic            load;
        logic [PC_W-1:0] value;
    } pc_ctl_t;

    typedef struct packed {
        logic            push;
        logic            pop;
        logic [PC_W-1:0] value;
    } stack_ctl_t;
endpackage

// >>> core/stack_pointer_extended_ops.sv
// decode and execute of the stack-pointer extended instructions
// assumes the core hands one instruction word per cycle with valid/ready, a data memory
// read combinationally from mem_raddr, and a return stack driven by push/pop pulses
//
// Functional notes
// RULE_01: the indexed-to-absolute move reads from stack_pointer_reg plus the 7-bit offset of word one, bit 7 clear.
// RULE_02: the indexed-to-absolute move writes to the 12-bit literal of the 1111-prefixed second word.
// RULE_03: both move addresses span the full 4096-byte space 000h to FFFh.
// RULE_04: software never aims either move at program_counter_low or the three return_stack_top bytes.
// RULE_05: a source address on an indirect addressing register moves the value 00h.
// RULE_06: the indexed-to-indexed move adds a 7-bit offset from each word to stack_pointer_reg, word one bit 7 set.
// RULE_07: an indexed-to-indexed destination on an indirect addressing register performs no write.
// RULE_08: literal_push writes its literal at stack_pointer_reg then decrements it by 1 in one cycle.
// RULE_09: pointer_subtract takes a 6-bit literal off pointer 0, 1 or 2 and touches no flag.
// RULE_10: subtract_and_return takes a 6-bit literal off stack_pointer_reg and loads the pc from the stack top.
// RULE_11: subtract_and_return is the pointer_subtract encoding with select field 11.
// RULE_12: subtract_and_return lasts two cycles, the second a no-operation.
// RULE_13: call_via_working_reg pushes pc plus 2 before loading the new pc.
// RULE_14: these instructions act only while extended_set_enable is 1; the code gates on the pin two cycles late and finishes a started move.
// RULE_15: a lone 1111-prefixed second word acts as a no-operation; the code runs a lone second word with high byte FAh as literal_push.
`timescale 1ns/10ps
module stack_pointer_extended_ops
(
    // clock and reset
    input  wire logic                           clk_sys,
    input  wire logic                           nrst,
    // configuration pin
    input  wire logic                           extended_set_enable,
    // instruction stream
    input  wire logic                           instr_valid,
    output logic                                instr_ready,
    input  wire logic [15:0]                    instr,
    input  wire logic [xop_pkg::PC_W-1:0]       pc,
    // core registers feeding calls and returns
    input  wire logic [xop_pkg::DATA_W-1:0]     working_reg,
    input  wire logic [xop_pkg::DATA_W-1:0]     pc_latch_high,
    input  wire logic [4:0]                     pc_latch_upper,
    input  wire logic [xop_pkg::PC_W-1:0]       return_stack_top,
    // data memory
    output logic [xop_pkg::ADDR_W-1:0]          mem_raddr,
    input  wire logic [xop_pkg::DATA_W-1:0]     mem_rdata,
    output xop_pkg::mem_wr_t                    mem_wr,
    // program counter and return stack
    output xop_pkg::pc_ctl_t                    pc_ctl,
    output xop_pkg::stack_ctl_t                 stack_ctl,
    // pointer registers, index 2 is stack_pointer_reg
    output logic [xop_pkg::PTR_N-1:0][xop_pkg::ADDR_W-1:0] pointer_regs
);
    // state
    xop_pkg::seq_state_t                        state;
    xop_pkg::seq_state_t                        next_state;
    logic [xop_pkg::PTR_N-1:0][xop_pkg::ADDR_W-1:0] next_pointer_regs;
    logic [xop_pkg::ADDR_W-1:0]                 next_mem_raddr;
    logic                                       move_is_ss;
    logic                                       next_move_is_ss;
    xop_pkg::mem_wr_t                           next_mem_wr;
    xop_pkg::pc_ctl_t                           next_pc_ctl;
    xop_pkg::stack_ctl_t                        next_stack_ctl;
    logic                                       ext_meta;
    logic                                       ext_en;

    // decode helpers
    logic                                       take;
    logic [7:0]                                 op_hi;
    logic [xop_pkg::ADDR_W-1:0]                 sp;
    logic [xop_pkg::ADDR_W-1:0]                 ofs_addr;
    logic [xop_pkg::ADDR_W-1:0]                 lit6;
    logic [1:0]                                 sel;
    logic                                       is_second;
    logic                                       src_ind;
    logic                                       dst_ind;

    // true when the address sits in an indirect addressing register window
    function automatic logic is_indirect(input logic [xop_pkg::ADDR_W-1:0] a);
        is_indirect = (a >= xop_pkg::IND_BASE0 && a < xop_pkg::IND_BASE0 + xop_pkg::IND_SPAN)
                   || (a >= xop_pkg::IND_BASE1 && a < xop_pkg::IND_BASE1 + xop_pkg::IND_SPAN)
                   || (a >= xop_pkg::IND_BASE2 && a < xop_pkg::IND_BASE2 + xop_pkg::IND_SPAN);
    endfunction

    // configuration pin passes two flip-flops
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            ext_meta <= 1'b0;
            ext_en   <= 1'b0;
        end
        else
        begin
            ext_meta <= extended_set_enable;
            ext_en   <= ext_meta;
        end
    end

    // field extraction, addresses wrap within the 12-bit space
    assign instr_ready = (state != xop_pkg::st_nop);
    assign take        = instr_valid && instr_ready;
    assign op_hi       = instr[15:8];
    assign sp          = pointer_regs[2];
    assign ofs_addr    = sp + {5'h00, instr[xop_pkg::OFS_HI:0]};            // RULE_03
    assign lit6        = {6'h00, instr[xop_pkg::LIT6_HI:0]};
    assign sel         = instr[xop_pkg::SEL_HI:xop_pkg::SEL_LO];
    assign is_second   = (instr[15:12] == xop_pkg::PREFIX_2ND);
    assign src_ind     = is_indirect(mem_raddr);
    assign dst_ind     = is_indirect(ofs_addr);

    // next-state and next-output computation
    always_comb
    begin
        next_state        = state;
        next_pointer_regs = pointer_regs;
        next_mem_raddr    = mem_raddr;
        next_move_is_ss   = move_is_ss;
        next_mem_wr       = '0;
        next_pc_ctl       = '0;
        next_stack_ctl    = '0;
        case (state)
            xop_pkg::st_idle:
            begin
                if (take && ext_en)                                          // RULE_14
                begin
                    if (op_hi == xop_pkg::OP_MOVE)
                    begin
                        // source read starts now, data is taken with word two
                        next_mem_raddr  = ofs_addr;                          // RULE_01
                        next_move_is_ss = instr[xop_pkg::MOVE_FORM_BIT];     // RULE_06
                        next_state      = xop_pkg::st_second;
                    end
                    else if (op_hi == xop_pkg::OP_PUSH)
                    begin
                        next_mem_wr.we       = 1'b1;                         // RULE_08
                        next_mem_wr.addr     = sp;
                        next_mem_wr.data     = instr[7:0];
                        next_pointer_regs[2] = sp - xop_pkg::SP_STEP;        // RULE_08
                    end
                    else if (op_hi == xop_pkg::OP_SUB)
                    begin
                        if (sel == xop_pkg::SEL_RETURN)                      // RULE_11
                        begin
                            next_pointer_regs[2] = sp - lit6;                // RULE_10
                            next_pc_ctl.load     = 1'b1;
                            next_pc_ctl.value    = return_stack_top;         // RULE_10
                            next_stack_ctl.pop   = 1'b1;
                            next_state           = xop_pkg::st_nop;          // RULE_12
                        end
                        else
                        begin
                            next_pointer_regs[sel] = pointer_regs[sel] - lit6; // RULE_09
                        end
                    end
                    else if (instr == xop_pkg::CALL_WORD)
                    begin
                        next_stack_ctl.push  = 1'b1;                         // RULE_13
                        next_stack_ctl.value = pc + xop_pkg::PC_STEP;
                        next_pc_ctl.load     = 1'b1;
                        next_pc_ctl.value    = {pc_latch_upper, pc_latch_high, working_reg};
                        next_state           = xop_pkg::st_nop;
                    end
                    // any other word, a lone second word among them, does nothing  RULE_15
                end
            end
            xop_pkg::st_second:
            begin
                if (take)
                begin
                    next_state = xop_pkg::st_idle;
                    if (is_second)
                    begin
                        next_mem_wr.data = src_ind ? xop_pkg::IND_DATA : mem_rdata; // RULE_05
                        if (move_is_ss)
                        begin
                            next_mem_wr.addr = ofs_addr;                     // RULE_06
                            next_mem_wr.we   = !dst_ind;                     // RULE_07
                        end
                        else
                        begin
                            next_mem_wr.addr = instr[11:0];                  // RULE_02
                            next_mem_wr.we   = 1'b1;                         // RULE_04
                        end
                    end
                end
            end
            xop_pkg::st_nop:
            begin
                next_state = xop_pkg::st_idle;                               // RULE_12
            end
            default:
            begin
                next_state = xop_pkg::st_idle;
            end
        endcase
    end

    // registers
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state        <= xop_pkg::st_idle;
            pointer_regs <= {xop_pkg::PTR_N{xop_pkg::PTR_RESET}};
            mem_raddr    <= xop_pkg::PTR_RESET;
            move_is_ss   <= 1'b0;
            mem_wr       <= '0;
            pc_ctl       <= '0;
            stack_ctl    <= '0;
        end
        else
        begin
            state        <= next_state;
            pointer_regs <= next_pointer_regs;
            mem_raddr    <= next_mem_raddr;
            move_is_ss   <= next_move_is_ss;
            mem_wr       <= next_mem_wr;
            pc_ctl       <= next_pc_ctl;
            stack_ctl    <= next_stack_ctl;
        end
    end

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    logic idle_take;
    assign idle_take = take && ext_en && (state == xop_pkg::st_idle);

    a_move_src_addr: assert property (idle_take && op_hi == xop_pkg::OP_MOVE
        |=> mem_raddr == 12'($past(sp) + {5'h00, $past(instr[6:0])}) && state == xop_pkg::st_second) // RULE_01
        else $error("move source address wrong");
    a_sf_dest_addr: assert property (take && state == xop_pkg::st_second && is_second && !move_is_ss
        |=> mem_wr.we && mem_wr.addr == $past(instr[11:0])) // RULE_02
        else $error("absolute destination wrong");
    a_src_ind_zero: assert property (take && state == xop_pkg::st_second && is_second && src_ind
        |=> mem_wr.data == xop_pkg::IND_DATA) // RULE_05
        else $error("indirect source not zero");
    a_ss_dest_nop: assert property (take && state == xop_pkg::st_second && is_second && move_is_ss
        |=> mem_wr.we == !$past(dst_ind) && mem_wr.addr == $past(ofs_addr)) // RULE_07
        else $error("indexed destination handling wrong");
    a_push_write: assert property (idle_take && op_hi == xop_pkg::OP_PUSH
        |=> mem_wr.we && mem_wr.addr == $past(sp) && mem_wr.data == $past(instr[7:0])
            && pointer_regs[2] == 12'($past(sp) - 12'h001)) // RULE_08
        else $error("push write or decrement wrong");
    a_ptr_sub: assert property (idle_take && op_hi == xop_pkg::OP_SUB && sel == 2'h0
        |=> pointer_regs[0] == 12'($past(pointer_regs[0]) - {6'h00, $past(instr[5:0])})
            && pointer_regs[2] == $past(pointer_regs[2])) // RULE_09
        else $error("pointer subtract wrong");
    a_ret_sequence: assert property (idle_take && op_hi == xop_pkg::OP_SUB && sel == 2'h3
        |=> pc_ctl.load && stack_ctl.pop && pc_ctl.value == $past(return_stack_top)
            && pointer_regs[2] == 12'($past(sp) - {6'h00, $past(instr[5:0])}) && !instr_ready
        ##1 instr_ready && !pc_ctl.load) // RULE_12
        else $error("subtract-and-return sequence wrong");
    a_call_push: assert property (idle_take && instr == 16'h0014
        |=> stack_ctl.push && stack_ctl.value == 21'($past(pc) + 21'h000002) && pc_ctl.load) // RULE_13
        else $error("call push wrong");
    a_disabled_quiet: assert property (take && !ext_en && state == xop_pkg::st_idle
        |=> !mem_wr.we && !pc_ctl.load && !stack_ctl.push && state == xop_pkg::st_idle) // RULE_14
        else $error("extended op ran while disabled");
    a_lone_second: assert property (idle_take && is_second && op_hi != xop_pkg::OP_PUSH
        |=> !mem_wr.we && $stable(pointer_regs) && state == xop_pkg::st_idle) // RULE_15
        else $error("lone second word acted");

    // no-operation cycle after a return or call is quiet on every strobe
    a_nop_quiet: assert property (state == xop_pkg::st_nop
        |=> !mem_wr.we && !pc_ctl.load && !stack_ctl.push && !stack_ctl.pop
            && $stable(pointer_regs)) // RULE_12
        else $error("no-operation cycle acted");
    // subtract-and-return leaves pointers 0 and 1 alone
    a_ret_sp_only: assert property (idle_take && op_hi == xop_pkg::OP_SUB && sel == 2'h3
        |=> pointer_regs[0] == $past(pointer_regs[0])
            && pointer_regs[1] == $past(pointer_regs[1])) // RULE_11
        else $error("subtract-and-return touched another pointer");
    // pointer 1 subtract leaves pointers 0 and 2 alone
    a_ptr1_sub: assert property (idle_take && op_hi == xop_pkg::OP_SUB && sel == 2'h1
        |=> pointer_regs[1] == 12'($past(pointer_regs[1]) - {6'h00, $past(instr[5:0])})
            && pointer_regs[0] == $past(pointer_regs[0])
            && pointer_regs[2] == $past(pointer_regs[2])) // RULE_09
        else $error("pointer 1 subtract wrong");
    // pointer 2 through the plain form never returns
    a_ptr2_sub: assert property (idle_take && op_hi == xop_pkg::OP_SUB && sel == 2'h2
        |=> pointer_regs[2] == 12'($past(sp) - {6'h00, $past(instr[5:0])})
            && !pc_ctl.load && state == xop_pkg::st_idle) // RULE_09
        else $error("pointer 2 subtract wrong");
    // a move whose next word lacks the prefix is dropped without a write
    a_move_dropped: assert property (take && state == xop_pkg::st_second && !is_second
        |=> !mem_wr.we && state == xop_pkg::st_idle) // RULE_02
        else $error("malformed move wrote");
    // a return or call holds the stream off for exactly one cycle
    a_ready_gap: assert property (pc_ctl.load |-> !instr_ready ##1 instr_ready) // RULE_12
        else $error("instruction stream not held for one cycle");
    // push moves only stack_pointer_reg
    a_push_others: assert property (idle_take && op_hi == xop_pkg::OP_PUSH
        |=> pointer_regs[0] == $past(pointer_regs[0])
            && pointer_regs[1] == $past(pointer_regs[1])) // RULE_08
        else $error("push touched another pointer");

    // main scenarios reached
    c_push: cover property (idle_take && op_hi == xop_pkg::OP_PUSH);
    c_move_ss: cover property (state == xop_pkg::st_second && take && move_is_ss ##1 mem_wr.we);
    c_ret: cover property (idle_take && op_hi == xop_pkg::OP_SUB && sel == 2'h3 ##2 instr_ready);
    c_call: cover property (idle_take && instr == xop_pkg::CALL_WORD ##1 stack_ctl.push);
    c_move_dropped: cover property (state == xop_pkg::st_second && take && !is_second);
endmodule

// >>> bench/data_mem_model.sv
// partner model of the on-chip data memory seen by the extended-op decoder
// assumes the decoder drives a registered mem_wr carrier and reads combinationally
`timescale 1ns/10ps
module data_mem_model
(
    // clock
    input  wire logic                       clk_sys,
    // read and write ports
    input  wire logic [xop_pkg::ADDR_W-1:0] raddr,
    output logic [xop_pkg::DATA_W-1:0]      rdata,
    input  wire xop_pkg::mem_wr_t           wr
);
    logic [xop_pkg::DATA_W-1:0] cells [0:4095];

    // seed every cell so that no read returns an unknown
    initial
    begin
        for (int i = 0; i < 4096; i++)
            cells[i] = 8'(i) ^ 8'h5a;
    end

    // reads settle in the same cycle as the address
    assign rdata = cells[raddr];

    // a write lands at the edge that closes the cycle holding we
    always @(posedge clk_sys)
    begin
        if (wr.we === 1'b1)
            cells[wr.addr] <= wr.data;
    end
endmodule

// >>> bench/tb_stack_pointer_extended_ops.sv
// self-checking bench for the stack-pointer extended-op decoder
// assumes a combinational data memory partner and one instruction per clock
`timescale 1ns/10ps
module tb_stack_pointer_extended_ops;
    logic                                           clk_sys = 1'b0;
    logic                                           nrst = 1'b0;
    logic                                           extended_set_enable = 1'b1;
    logic                                           instr_valid = 1'b0;
    logic                                           instr_ready;
    logic [15:0]                                    instr = 16'h0000;
    logic [20:0]                                    pc = 21'h001004;
    logic [7:0]                                     working_reg = 8'h06;
    logic [7:0]                                     pc_latch_high = 8'h10;
    logic [4:0]                                     pc_latch_upper = 5'h00;
    logic [20:0]                                    return_stack_top = 21'h0abcd;
    logic [11:0]                                    mem_raddr;
    logic [7:0]                                     mem_rdata;
    xop_pkg::mem_wr_t                               mem_wr;
    xop_pkg::pc_ctl_t                               pc_ctl;
    xop_pkg::stack_ctl_t                            stack_ctl;
    logic [xop_pkg::PTR_N-1:0][xop_pkg::ADDR_W-1:0] pointer_regs;
    logic [11:0]                                    p_exp [0:2];
    int                                             error_cnt = 0;
    int                                             samples_checked = 0;

    stack_pointer_extended_ops dut (.clk_sys(clk_sys), .nrst(nrst),
        .extended_set_enable(extended_set_enable), .instr_valid(instr_valid),
        .instr_ready(instr_ready), .instr(instr), .pc(pc), .working_reg(working_reg),
        .pc_latch_high(pc_latch_high), .pc_latch_upper(pc_latch_upper),
        .return_stack_top(return_stack_top), .mem_raddr(mem_raddr), .mem_rdata(mem_rdata),
        .mem_wr(mem_wr), .pc_ctl(pc_ctl), .stack_ctl(stack_ctl), .pointer_regs(pointer_regs));
    data_mem_model mem (.clk_sys(clk_sys), .raddr(mem_raddr), .rdata(mem_rdata), .wr(mem_wr));

    // 100 MHz clock
    always #5 clk_sys = ~clk_sys;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // offer a word and hold it until the edge that takes it; effects are then visible
    task automatic issue(input logic [15:0] w);
        int n;
        n = 0;
        instr = w;
        instr_valid = 1'b1;
        while (instr_ready !== 1'b1 && n < 10)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n == 10)
            error_cnt++;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic idle(input int cycles);
        instr_valid = 1'b0;
        repeat (cycles) @(posedge clk_sys);
        #1;
    endtask

    task automatic push1(input logic [7:0] k);
        issue({8'hfa, k});
        chk(mem_wr.we, 1'b1);
        chk(mem_wr.addr, p_exp[2]);
        chk(mem_wr.data, k);
        p_exp[2] = p_exp[2] - 12'h001;
        chk(pointer_regs[2], p_exp[2]);
    endtask

    task automatic t_push();
        push1(8'h08);
        push1(8'h3c);
        idle(1);
        $display("test push done");
    endtask

    task automatic t_subtract();
        logic [5:0] ks [0:2];
        ks = '{6'h01, 6'h3f, 6'h13};
        for (int s = 0; s < 3; s++)
        begin
            issue({8'he9, 2'(s), ks[s]});
            p_exp[s] = p_exp[s] - {6'h00, ks[s]};
            chk(mem_wr.we, 1'b0);
            for (int j = 0; j < 3; j++)
                chk(pointer_regs[j], p_exp[j]);
        end
        idle(1);
        $display("test pointer subtract done");
    endtask

    // destinations stay clear of the pc and return-stack bytes
    task automatic mv(input logic [15:0] w1, input logic [15:0] w2, input logic we,
                      input logic [11:0] a, input logic [7:0] d);
        issue(w1);
        chk(mem_raddr, 12'(p_exp[2] + {5'h00, w1[6:0]}));
        issue(w2);
        chk(mem_wr.we, we);
        if (we)
        begin
            chk(mem_wr.addr, a);
            chk(mem_wr.data, d);
        end
        chk(pointer_regs[2], p_exp[2]);
    endtask

    task automatic t_moves();
        mv(16'heb00, 16'hf123, 1'b1, 12'h123, 8'h00);
        mv(16'heb14, 16'hfe00, 1'b1, 12'he00, 8'h3c);
        mv(16'heb95, 16'hf020, 1'b1, 12'h00b, 8'h08);
        mv(16'heb95, 16'hf002, 1'b0, 12'h000, 8'h00);
        // a move whose next word lacks the prefix swallows that word
        issue(16'heb00);
        issue(16'h0014);
        chk({mem_wr.we, pc_ctl.load, stack_ctl.push}, 3'h0);
        issue(16'hf123);
        chk(mem_wr.we, 1'b0);
        chk(pointer_regs[2], p_exp[2]);
        idle(1);
        $display("test moves done");
    endtask

    task automatic t_ret_call();
        issue(16'he9e3);
        p_exp[2] = p_exp[2] - 12'h023;
        chk(pointer_regs[2], p_exp[2]);
        chk({pc_ctl.load, stack_ctl.pop}, 2'h3);
        chk(pc_ctl.value, return_stack_top);
        chk(instr_ready, 1'b0);
        idle(1);
        chk({instr_ready, pc_ctl.load, stack_ctl.pop}, 3'h4);
        issue(16'h0014);
        chk({stack_ctl.push, stack_ctl.pop, pc_ctl.load}, 3'h5);
        chk(stack_ctl.value, pc + 21'h000002);
        chk(pc_ctl.value, {pc_latch_upper, pc_latch_high, working_reg});
        idle(1);
        $display("test return and call done");
    endtask

    task automatic t_disabled();
        extended_set_enable = 1'b0;
        idle(3);
        issue(16'hfa55);
        chk(mem_wr.we, 1'b0);
        chk(pointer_regs[2], p_exp[2]);
        idle(1);
        $display("test disabled done");
    endtask

    // watchdog against a hung handshake
    initial
    begin
        #20000;
        error_cnt++;
        results();
    end

    // main sequence
    initial
    begin
        p_exp = '{12'h000, 12'h000, 12'h000};
        repeat (3) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        idle(3);
        t_push();
        t_subtract();
        t_moves();
        t_ret_call();
        t_disabled();
        results();
    end
endmodule
